// File: scpi_command_parser.v
`timescale 1ns/1ps
`include "parser_defines.vh"
module scpi_command_parser #(
  parameter BUF_CAP = `BUF_CAP_CHARS, // longest message in characters
  parameter FIFO_DEPTH = 4 // reply buffer words
) (
  input wire clk, // 200 MHz system clock
  input wire reset, // synchronous, active high
  input wire ce, // clock enable, freezes all state
  input wire [7:0] rx_data, // received character
  input wire rx_valid, // character offered
  output wire rx_ready, // character taken when valid too
  input wire range_high, // higher output voltage range active
  output wire [7:0] tx_data, // reply character
  output wire tx_valid, // reply character offered
  input wire tx_ready, // link takes reply character
  output reg [6:0] current_limit, // rms limit, tenths of an ampere
  output reg limit_update, // pulse: limit written
  output reg cmd_error, // pulse: command rejected
  output reg common_strobe, // pulse: common command decoded
  output reg [23:0] common_code, // its three letters, upper case
  output reg common_query // common command had a question mark
);
  localparam [10:0] S_HDR = 11'h001;
  localparam [10:0] S_WS = 11'h002;
  localparam [10:0] S_NUM = 11'h004;
  localparam [10:0] S_CHR = 11'h008;
  localparam [10:0] S_END = 11'h010;
  localparam [10:0] S_BHASH = 11'h020;
  localparam [10:0] S_BLEN = 11'h040;
  localparam [10:0] S_BDATA = 11'h080;
  localparam [10:0] S_NORM = 11'h100;
  localparam [10:0] S_REPLY = 11'h200;
  localparam [10:0] S_SKIP = 11'h400;

  reg [10:0] state;
  reg [1:0] lvl;
  reg [63:0] kb;
  reg [3:0] klen;
  reg at_start;
  reg common;
  reg query;
  reg is_bin;
  reg [19:0] mant;
  reg [3:0] fc;
  reg [4:0] e;
  reg eneg;
  reg neg;
  reg pt;
  reg dig;
  reg in_exp;
  reg edig;
  reg ovf;
  reg [6:0] scale;
  reg term_lf;
  reg [3:0] bn;
  reg [15:0] blen;
  reg [2:0] ri;
  reg [31:0] msg_cnt;
  reg [2:0] kw_id;
  reg [2:0] nxt_lvl;
  reg [7:0] rchar;

  wire [7:0] c = rx_data;
  wire [7:0] uc;
  wire [3:0] d = rx_data[3:0];
  wire is_dig;
  wire is_alpha;
  wire acc;
  wire is_lf;
  wire is_term;
  wire bool_ok;
  wire num_bad;
  wire [23:0] m_acc;
  wire [23:0] m10;
  wire [19:0] div10;
  wire [8:0] e_acc;
  wire [19:0] bl10;
  wire [6:0] scale0;
  wire tens;
  wire [6:0] rem7;
  wire [6:0] units;
  wire [6:0] tenth;
  wire fifo_in_ready;

  ////////////////////////////////////////////////////////////////////////////
  // character classes
  assign uc = (c >= 8'h61 && c <= 8'h7a) ? c - 8'h20 : c;
  assign is_dig = (c >= 8'h30) && (c <= 8'h39);
  assign is_alpha = (uc >= 8'h41) && (uc <= 8'h5a);
  assign rx_ready = ce && (state != S_NORM) && (state != S_REPLY);
  assign acc = rx_valid && rx_ready;
  // binary payload may hold any byte, LF included
  assign is_lf = (c == `CH_LF) && (state != S_BDATA);
  assign is_term = is_lf || (c == `CH_SEMI);

  ////////////////////////////////////////////////////////////////////////////
  // numeric helpers
  assign m_acc = {1'b0, mant, 3'b000} + {3'b000, mant, 1'b0} + {20'h00000, d};
  assign m10 = {1'b0, mant, 3'b000} + {3'b000, mant, 1'b0};
  assign div10 = mant / 20'h0000a;
  assign e_acc = {1'b0, e, 3'b000} + {3'b000, e, 1'b0} + {5'h00, d};
  assign bl10 = {1'b0, blen, 3'b000} + {3'b000, blen, 1'b0} + {16'h0000, d};
  // value kept in tenths, so the decimal point sits one place right
  assign scale0 = 7'h01 + (eneg ? 7'h00 - {2'b00, e} : {2'b00, e}) - {3'b000, fc};
  assign bool_ok = (klen == 4'h2 && kb[15:0] == `KW_ON) ||
                   (klen == 4'h3 && kb[23:0] == `KW_OFF);
  assign num_bad = (state == S_CHR) ? !bool_ok : (!dig || (in_exp && !edig));

  ////////////////////////////////////////////////////////////////////////////
  // reply digits
  assign tens = current_limit >= 7'h64;
  assign rem7 = tens ? current_limit - 7'h64 : current_limit;
  assign units = rem7 / 7'h0a;
  assign tenth = rem7 % 7'h0a;

  always @* begin
    case (ri)
      3'h0: rchar = 8'h31;
      3'h1: rchar = {4'h3, units[3:0]};
      3'h2: rchar = `CH_DOT;
      3'h3: rchar = {4'h3, tenth[3:0]};
      default: rchar = `CH_LF;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // keyword match, short or full form only
  always @* begin
    kw_id = `ID_NONE;
    case (klen)
      4'h3: begin
        if (kb[23:0] == `KW_LIM) kw_id = `ID_LIM;
        else if (kb[23:0] == `KW_RMS) kw_id = `ID_RMS;
        else if (kb[23:0] == `KW_AVE) kw_id = `ID_AVE;
      end
      4'h4: begin
        if (kb[31:0] == `KW_SOUR) kw_id = `ID_SOUR;
        else if (kb[31:0] == `KW_CURR) kw_id = `ID_CURR;
      end
      4'h5: if (kb[39:0] == `KW_LIMIT) kw_id = `ID_LIM;
      4'h6: if (kb[47:0] == `KW_SOURCE) kw_id = `ID_SOUR;
      4'h7: begin
        if (kb[55:0] == `KW_CURRENT) kw_id = `ID_CURR;
        else if (kb[55:0] == `KW_AVERAGE) kw_id = `ID_AVE;
      end
      default: kw_id = `ID_NONE;
    endcase
  end

  // tree walk from the current path
  always @* begin
    nxt_lvl = `LVL_BAD;
    case (lvl)
      2'h0: begin
        if (kw_id == `ID_SOUR) nxt_lvl = 3'h1;
        else if (kw_id == `ID_CURR) nxt_lvl = 3'h2;
      end
      2'h1: if (kw_id == `ID_CURR) nxt_lvl = 3'h2;
      2'h2: if (kw_id == `ID_LIM) nxt_lvl = 3'h3;
      default: if (kw_id == `ID_RMS || kw_id == `ID_AVE) nxt_lvl = `LVL_LEAF;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // command sequencing
  task done;
    input lf;
    begin
      state <= S_HDR;
      at_start <= 1'b1;
      klen <= 4'h0;
      common <= 1'b0;
      query <= 1'b0;
      is_bin <= 1'b0;
      mant <= 20'h00000;
      fc <= 4'h0;
      e <= 5'h00;
      eneg <= 1'b0;
      neg <= 1'b0;
      pt <= 1'b0;
      dig <= 1'b0;
      in_exp <= 1'b0;
      edig <= 1'b0;
      ovf <= 1'b0;
      if (lf) lvl <= 2'h0;
    end
  endtask

  task raise;
    input lf;
    begin
      cmd_error <= 1'b1;
      if (lf) done(1'b1);
      else state <= S_SKIP;
    end
  endtask

  task finish;
    input lf;
    begin
      term_lf <= lf;
      if (common) begin
        common_strobe <= 1'b1;
        common_query <= query;
        done(lf);
      end else if (query) begin
        ri <= tens ? 3'h0 : 3'h1;
        state <= S_REPLY;
      end else if (is_bin || num_bad) begin
        raise(lf);
      end else begin
        scale <= scale0;
        state <= S_NORM;
      end
    end
  endtask

  task num_char;
    begin
      if (is_dig && in_exp) begin
        e <= (e_acc > 9'h010) ? 5'h10 : e_acc[4:0];
        edig <= 1'b1;
      end else if (is_dig) begin
        if (m_acc[23:20] != 4'h0) ovf <= 1'b1;
        else mant <= m_acc[19:0];
        if (pt && fc != 4'hf) fc <= fc + 4'h1;
        dig <= 1'b1;
      end else if (c == `CH_DOT && !pt && !in_exp) begin
        pt <= 1'b1;
      end else if (uc == `CH_E && dig && !in_exp) begin
        in_exp <= 1'b1;
      end else if ((c == `CH_PLUS || c == `CH_MINUS) && state == S_WS) begin
        neg <= (c == `CH_MINUS);
      end else if ((c == `CH_PLUS || c == `CH_MINUS) && in_exp && !edig) begin
        eneg <= (c == `CH_MINUS);
      end else begin
        raise(1'b0);
      end
    end
  endtask

  always @(posedge clk) begin
    if (reset) begin
      done(1'b1);
      current_limit <= `LIM_RESET;
      limit_update <= 1'b0;
      cmd_error <= 1'b0;
      common_strobe <= 1'b0;
      common_code <= 24'h000000;
      common_query <= 1'b0;
      kb <= 64'h0;
      scale <= 7'h00;
      term_lf <= 1'b0;
      bn <= 4'h0;
      blen <= 16'h0000;
      ri <= 3'h0;
      msg_cnt <= 32'h0;
    end else if (ce) begin
      limit_update <= 1'b0;
      cmd_error <= 1'b0;
      common_strobe <= 1'b0;
      if (acc) msg_cnt <= is_lf ? 32'h0 : msg_cnt + 32'h1;
      if (acc && state != S_SKIP &&
          ((c[7] && state != S_BDATA) || msg_cnt >= BUF_CAP)) begin
        raise(is_lf);
      end else begin
        case (state)
          S_HDR: if (acc) begin
            if (is_alpha || is_dig) begin
              kb <= {kb[55:0], uc};
              klen <= (klen == 4'hf) ? klen : klen + 4'h1;
              at_start <= 1'b0;
            end else if (c == `CH_COLON && at_start) begin
              lvl <= 2'h0;
              at_start <= 1'b0;
            end else if (c == `CH_COLON) begin
              if (common || nxt_lvl[2]) raise(1'b0);
              else begin
                lvl <= nxt_lvl[1:0];
                klen <= 4'h0;
              end
            end else if (c == `CH_STAR && at_start) begin
              common <= 1'b1;
              at_start <= 1'b0;
            end else if (is_term && at_start) begin
              if (is_lf) lvl <= 2'h0;
            end else if (is_term || c == `CH_SP || c == `CH_QUEST) begin
              if (common ? (klen != 4'h3) : (nxt_lvl != `LVL_LEAF)) begin
                raise(is_lf);
              end else begin
                if (common) common_code <= kb[23:0];
                if (c == `CH_QUEST) begin
                  query <= 1'b1;
                  state <= S_END;
                end else if (c == `CH_SP) begin
                  state <= S_WS;
                end else if (common) begin
                  finish(is_lf);
                end else begin
                  raise(is_lf);
                end
              end
            end else begin
              raise(is_lf);
            end
          end
          S_WS: if (acc && c != `CH_SP) begin
            if (c == `CH_QUEST) begin
              query <= 1'b1;
              state <= S_END;
            end else if (c == `CH_HASH) begin
              is_bin <= 1'b1;
              state <= S_BHASH;
            end else if (is_alpha) begin
              kb <= {kb[55:0], uc};
              klen <= 4'h1;
              state <= S_CHR;
            end else if (is_dig || c == `CH_DOT || c == `CH_PLUS || c == `CH_MINUS) begin
              state <= S_NUM;
              num_char;
            end else begin
              raise(is_lf);
            end
          end
          S_NUM: if (acc) begin
            if (c == `CH_SP) state <= S_END;
            else if (is_term) finish(is_lf);
            else num_char;
          end
          S_CHR: if (acc) begin
            if (is_alpha) begin
              kb <= {kb[55:0], uc};
              klen <= (klen == 4'hf) ? klen : klen + 4'h1;
            end else if (c == `CH_SP || is_term) begin
              mant <= {19'h00000, klen == 4'h2};
              dig <= bool_ok;
              if (c == `CH_SP) state <= S_END;
              else finish(is_lf);
            end else begin
              raise(is_lf);
            end
          end
          S_END: if (acc) begin
            if (is_term) finish(is_lf);
            else if (c != `CH_SP) raise(1'b0);
          end
          S_BHASH: if (acc) begin
            if (is_dig && d != 4'h0) begin
              bn <= d;
              blen <= 16'h0000;
              state <= S_BLEN;
            end else begin
              raise(is_lf);
            end
          end
          S_BLEN: if (acc) begin
            if (is_dig) begin
              blen <= bl10[15:0];
              bn <= bn - 4'h1;
              if (bn == 4'h1) state <= (bl10[15:0] == 16'h0000) ? S_END : S_BDATA;
            end else begin
              raise(is_lf);
            end
          end
          S_BDATA: if (acc) begin
            blen <= blen - 16'h0001;
            if (blen == 16'h0001) state <= S_END;
          end
          S_NORM: begin
            if (neg || ovf) begin
              raise(term_lf);
            end else if (scale[6]) begin
              mant <= div10;
              scale <= scale + 7'h01;
            end else if (scale != 7'h00) begin
              if (m10[23:20] != 4'h0) ovf <= 1'b1;
              else mant <= m10[19:0];
              scale <= scale - 7'h01;
            end else if (mant >= `LIM_MIN &&
                         mant <= (range_high ? `LIM_MAX_HI : `LIM_MAX_LO)) begin
              current_limit <= mant[6:0];
              limit_update <= 1'b1;
              done(term_lf);
            end else begin
              raise(term_lf);
            end
          end
          S_REPLY: if (fifo_in_ready) begin
            if (ri == 3'h4) done(term_lf);
            else ri <= ri + 3'h1;
          end
          S_SKIP: if (acc && is_lf) done(1'b1);
          default: done(1'b1);
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reply buffer
  reply_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_reply_fifo (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .in_valid(state == S_REPLY),
    .in_ready(fifo_in_ready),
    .in_data(rchar),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );
endmodule // scpi_command_parser

// File: parser_defines.vh
// Summary of operation
// - all received characters outside binary blocks, and all replied characters, are ASCII
// - accept integer, decimal, exponent numbers and ON/OFF
// - binary block: hash, digit count, length, bytes
// - asterisk plus three letters is a common command
// - each colon after a keyword moves the path one level down
// - path returns to root: reset, leading colon, LF
// - leading colon is optional on the first command of a message, same meaning
// - semicolon keeps current path for next command
// - keyword letters match regardless of case
// - keyword accepted in short or full form
// - any other keyword length is an error
// - optional keywords may be left out
// - trailing question mark makes a query
// - reply holds only the value, no header
// - space separates header from parameter
// - rms limit 1.0-10.5 or 1.0-5.3, decimal reply
// - average limit keyword aliases the rms limit
// - message length is capped by buffer capacity
// - illegal command skips rest of message
`ifndef PARSER_DEFINES_VH
`define PARSER_DEFINES_VH

// characters
`define CH_LF 8'h0a
`define CH_SP 8'h20
`define CH_HASH 8'h23
`define CH_STAR 8'h2a
`define CH_PLUS 8'h2b
`define CH_MINUS 8'h2d
`define CH_DOT 8'h2e
`define CH_COLON 8'h3a
`define CH_SEMI 8'h3b
`define CH_QUEST 8'h3f
`define CH_E 8'h45

// keywords, upper case
`define KW_SOUR 32'h534f5552
`define KW_SOURCE 48'h534f55524345
`define KW_CURR 32'h43555252
`define KW_CURRENT 56'h43555252454e54
`define KW_LIM 24'h4c494d
`define KW_LIMIT 40'h4c494d4954
`define KW_RMS 24'h524d53
`define KW_AVE 24'h415645
`define KW_AVERAGE 56'h41564552414745
`define KW_ON 16'h4f4e
`define KW_OFF 24'h4f4646

// keyword ids and tree levels
`define ID_NONE 3'h0
`define ID_SOUR 3'h1
`define ID_CURR 3'h2
`define ID_LIM 3'h3
`define ID_RMS 3'h4
`define ID_AVE 3'h5
`define LVL_LEAF 3'h4
`define LVL_BAD 3'h7

// limit in tenths of an ampere
`define LIM_MIN 20'h0000a
`define LIM_MAX_LO 20'h00069
`define LIM_MAX_HI 20'h00035
`define LIM_RESET 7'h32

// input buffer capacity in characters
`define BUF_CAP_CHARS 10000

`endif

// File: reply_fifo.v
`timescale 1ns/1ps
module reply_fifo #(
  parameter WIDTH = 8, // bits per word
  parameter DEPTH = 4 // words, power of two
) (
  input wire clk, // system clock
  input wire reset, // synchronous, active high
  input wire ce, // clock enable
  input wire in_valid, // write word offered
  output wire in_ready, // room for a word
  input wire [WIDTH-1:0] in_data, // write word
  output wire out_valid, // word available
  input wire out_ready, // reader takes word
  output wire [WIDTH-1:0] out_data // head word
);
  localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam [AW:0] FULL = DEPTH;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready = ce && (count != FULL);
  assign out_valid = ce && (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else if (ce) begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // reply_fifo

// File: scpi_command_parser_checker.sv
`timescale 1ns/1ps
module scpi_command_parser_checker #(
  parameter BUF_CAP = 40, // longest message
  parameter FIFO_DEPTH = 4 // reply words
) (
  input wire clk, // clock
  input wire reset, // sync reset
  input wire rx_ready, // char taken
  input wire range_high, // high range
  input wire [7:0] tx_data, // reply char
  input wire tx_valid, // reply offered
  input wire tx_ready, // reply taken
  input wire [6:0] current_limit, // limit, tenths
  input wire limit_update, // limit pulse
  input wire cmd_error, // error pulse
  input wire common_strobe, // common pulse
  input wire [23:0] common_code // common letters
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  function automatic logic an(input logic [7:0] c);
    an = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h5a);
  endfunction
  sequence tx_stall;
    tx_valid && !tx_ready;
  endsequence
  sequence tx_kept;
    tx_valid && $stable(tx_data);
  endsequence
  chk_error_pulse_once: assert property (cmd_error |=> !cmd_error)
    else $error("error pulse too long");
  chk_update_pulse_once: assert property (limit_update |=> !limit_update)
    else $error("update pulse too long");
  chk_limit_in_range: assert property (limit_update |-> current_limit >= 7'h0a &&
    current_limit <= (range_high ? 7'h35 : 7'h69)) else $error("limit out of range");
  chk_limit_change_flagged: assert property ($changed(current_limit) |-> limit_update)
    else $error("limit changed silently");
  chk_error_keeps_limit: assert property (cmd_error |-> $stable(current_limit))
    else $error("limit changed on error");
  chk_busy_while_check: assert property (limit_update |-> !$past(rx_ready))
    else $error("input open while checking value");
  chk_reply_value_only: assert property (tx_valid |-> tx_data == 8'h0a ||
    tx_data == 8'h2e || (tx_data >= 8'h30 && tx_data <= 8'h39)) else $error("bad reply char");
  chk_reply_held: assert property (tx_stall |=> tx_kept)
    else $error("reply char dropped while stalled");
  chk_common_upper: assert property (common_strobe |-> an(common_code[23:16]) &&
    an(common_code[15:8]) && an(common_code[7:0])) else $error("common code not upper");
endmodule // scpi_command_parser_checker
bind scpi_command_parser scpi_command_parser_checker #(.BUF_CAP(BUF_CAP),
  .FIFO_DEPTH(FIFO_DEPTH)) i_chk (.clk(clk), .reset(reset), .rx_ready(rx_ready),
  .range_high(range_high), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .current_limit(current_limit), .limit_update(limit_update), .cmd_error(cmd_error),
  .common_strobe(common_strobe), .common_code(common_code));

// File: host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire clk, // clock
  output reg [7:0] rx_data, // char to device
  output reg rx_valid, // char offered
  input wire rx_ready, // device takes char
  input wire [7:0] tx_data, // reply char
  input wire tx_valid, // reply offered
  output reg tx_ready // host takes reply
);
  reg stall = 1'b0; // slow reader
  reg [1:0] phase = 2'h0;
  reg take = 1'b0;
  reg [7:0] got = 8'h00;
  reg [63:0] reply = 64'h0; // newest char lowest
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
  end
  always @(posedge clk) begin
    phase <= phase + 2'h1;
    tx_ready <= !stall || (phase == 2'h3);
  end
  // sample off the edge to avoid races
  always @(negedge clk) begin
    take = tx_valid && tx_ready;
    got = tx_data;
  end
  always @(posedge clk) if (take) reply <= {reply[55:0], got};
  task clear;
    reply = 64'h0;
  endtask
  // call at a rising edge; message length is the caller's duty
  task send(input string s);
    integer i;
    for (i = 0; i < s.len(); i = i + 1) begin
      rx_data <= s[i];
      rx_valid <= 1'b1;
      @(negedge clk);
      while (!rx_ready) @(negedge clk);
      @(posedge clk);
    end
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
  endtask
endmodule // host_model

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg clk, reset, ce, range_high;
  wire [7:0] rx_data, tx_data;
  wire rx_valid, rx_ready, tx_valid, tx_ready, limit_update, cmd_error, common_strobe;
  wire common_query;
  wire [6:0] current_limit;
  wire [23:0] common_code;
  integer error_cnt = 0, n_compared = 0, cyc = 0, n_err = 0, n_upd = 0, n_com = 0;
  reg [23:0] com_code = 24'h0;
  reg com_q = 1'b0;
  string vals [0:9] = '{"3", "4.25", "0.61E1", "ON", "-2", "OFF", "5.4", "5.3", "10.5", "10.6"};
  reg [6:0] exps [0:9] = '{7'h1e, 7'h2a, 7'h3d, 7'h0a, 7'h0a, 7'h0a, 7'h0a, 7'h35, 7'h69, 7'h69};
  reg [9:0] errs = 10'h270;
  reg [9:0] highs = 10'h0c0;
  scpi_command_parser #(.BUF_CAP(40), .FIFO_DEPTH(4)) i_dut (.clk(clk), .reset(reset),
    .ce(ce), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .range_high(range_high), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .current_limit(current_limit), .limit_update(limit_update), .cmd_error(cmd_error),
    .common_strobe(common_strobe), .common_code(common_code), .common_query(common_query));
  host_model i_host (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(negedge clk) begin
    if (cmd_error === 1'b1) n_err = n_err + 1;
    if (limit_update === 1'b1) n_upd = n_upd + 1;
    if (common_strobe === 1'b1) begin
      n_com = n_com + 1;
      com_code = common_code;
      com_q = common_query;
    end
  end
  ////////////////////////////////////////////////////////////////
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      test_done;
    end
  end
  task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function [63:0] vec(input string s);
    integer i;
    vec = 64'h0;
    for (i = 0; i < s.len(); i = i + 1) vec = {vec[55:0], s[i]};
  endfunction
  // normalise takes at most about 35 cycles, replies a few more
  task cmd(input string s);
    n_err = 0;
    n_upd = 0;
    n_com = 0;
    i_host.clear;
    i_host.send(s);
    repeat (80) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////
  task t_reset;
    check("reset limit", current_limit, 7'h32);
    cmd("CURR:LIM:RMS?\n");
    check("reply", i_host.reply, vec("5.0\n"));
    $display("test reset done");
  endtask
  task t_forms;
    cmd(":SOURce:CURRENT:LIMIT:rms 7.5\n");
    check("limit", current_limit, 7'h4b);
    cmd("curr:Lim:RMS?\n");
    check("reply", i_host.reply, vec("7.5\n"));
    $display("test forms done");
  endtask
  task t_values;
    integer i;
    for (i = 0; i < 10; i = i + 1) begin
      range_high <= highs[i];
      cmd({"CURR:LIM:RMS ", vals[i], "\n"});
      check("limit", current_limit, exps[i]);
      check("error", n_err, errs[i]);
      check("update", n_upd, !errs[i]);
    end
    range_high <= 1'b0;
    $display("test values done");
  endtask
  task t_stall;
    i_host.stall = 1'b1;
    cmd("CURR:LIM:RMS?;RMS?\n");
    i_host.stall = 1'b0;
    check("reply", i_host.reply, vec(".5\n10.5\n"));
    $display("test stall done");
  endtask
  task t_alias;
    cmd("CURR:LIM:RMS 2;AVE?\n");
    check("limit", current_limit, 7'h14);
    check("reply", i_host.reply, vec("2.0\n"));
    cmd("CURR:LIM:AVErage 3\n");
    check("limit", current_limit, 7'h1e);
    $display("test alias done");
  endtask
  task t_path;
    cmd("AVE?\n");
    check("error", n_err, 1);
    cmd("CURR:LIM:RMS 4;:AVE 6\n");
    check("limit", current_limit, 7'h28);
    check("error", n_err, 1);
    $display("test path done");
  endtask
  task t_keyword;
    cmd("CURRE:LIM:RMS 6;CURR:LIM:RMS 7\n");
    check("error", n_err, 1);
    cmd("CUR:LIM:RMS 6\n");
    check("error", n_err, 1);
    check("limit", current_limit, 7'h28);
    $display("test keyword done");
  endtask
  task t_common;
    cmd("*idn?\n");
    check("code", {n_com, com_code, com_q}, {32'd1, 24'h49444e, 1'b1});
    cmd("*ESE #14a\nbc\n");
    check("error", n_err, 0);
    check("code", {n_com, com_code}, {32'd1, 24'h455345});
    $display("test common done");
  endtask
  task t_faults;
    string s;
    integer i;
    s = "CURR:LIM:RMS 8.";
    for (i = 0; i < 30; i = i + 1) s = {s, "0"};
    cmd({s, "\n"});
    check("error", n_err, 1);
    s = "CURR:LIM:RMS 8\n";
    s[2] = 8'hd5;
    cmd(s);
    check("error", n_err, 1);
    cmd("CURR:LIM:RMS #12ab\n");
    check("error", n_err, 1);
    check("limit", current_limit, 7'h28);
    cmd("CURR:LIM:RMS 8\n");
    check("limit", current_limit, 7'h50);
    $display("test faults done");
  endtask
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    range_high = 1'b0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset;
    t_forms;
    t_values;
    t_stall;
    t_alias;
    t_path;
    t_keyword;
    t_common;
    t_faults;
    test_done;
  end
endmodule // tb_top
